// ===== ivob_defs.svh
// address map, field positions, reset values and bus codes of the bank
`ifndef IVOB_DEFS_SVH
`define IVOB_DEFS_SVH

// bus address and data widths and alias operation bits
`define IVOB_ADDR_W      12
`define IVOB_DATA_W      32
`define IVOB_ALIAS_MASK  12'h00c
`define IVOB_OP_HI       3
`define IVOB_OP_LO       2

// controller registers that carry clear, set and invert aliases
`define IVOB_FLAG_ADDR   12'h000
`define IVOB_IEN_ADDR    12'h010
`define IVOB_PEN_ADDR    12'h020

// vector offset registers, base address only
`define IVOB_VOFF41_ADDR 12'h5e4
`define IVOB_VOFF42_ADDR 12'h5e8
`define IVOB_VOFF43_ADDR 12'h5ec
`define IVOB_VOFF44_ADDR 12'h5f0
`define IVOB_VOFF45_ADDR 12'h5f4
`define IVOB_VOFF46_ADDR 12'h5f8
`define IVOB_VOFF47_ADDR 12'h5fc
`define IVOB_VOFF48_ADDR 12'h600
`define IVOB_VOFF49_ADDR 12'h604
`define IVOB_VOFF50_ADDR 12'h608
`define IVOB_VOFF53_ADDR 12'h614
`define IVOB_VOFF54_ADDR 12'h618
`define IVOB_VOFF55_ADDR 12'h61c
`define IVOB_VOFF56_ADDR 12'h620
`define IVOB_NUM_VEC     14

// vector offset field position and reset value
`define IVOB_VECTOR_OFFSET_FIELD_MSB    17
`define IVOB_VECTOR_OFFSET_FIELD_LSB    1
`define IVOB_VECTOR_OFFSET_FIELD_W      17
`define IVOB_VECTOR_OFFSET_FIELD_RST    17'h00000
`define IVOB_CTRL_RST    32'h00000000

// axi response codes
`define IVOB_RESP_OKAY   2'h0
`define IVOB_RESP_SLVERR 2'h2

`endif

// ===== ivob_pkg.sv
// types shared by the vector offset bank
package ivob_pkg;

  // write channel progress
  typedef enum logic {wr_collect, wr_resp} wr_state_t;

  // register group hit by an address
  typedef enum logic [2:0] {
    grp_none, grp_flag, grp_ien, grp_pen, grp_vec
  } reg_grp_t;

  // alias operation selected by address bits 3:2
  typedef enum logic [1:0] {op_base, op_clr, op_set, op_inv} alias_op_t;

endpackage : ivob_pkg

// ===== interrupt_vector_offset_bank.sv
// What this block does
// - flag, enable registers have clear/set/invert aliases
// - vector offsets: base address only, plain replace
// - enabled peripheral event sets its flag
// - flag setting ignores the interrupt enable
// - flags stay set until software clears
// - unimplemented bits read zero, ignore writes
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ivob_defs.svh"

module interrupt_vector_offset_bank #(
  parameter int N_EVT = 8                        // event sources
) (
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  input  wire logic                    ce,       // low freezes all state
  // axi4-lite write address
  input  wire logic [`IVOB_ADDR_W-1:0] awaddr,
  input  wire logic [2:0]              awprot,
  input  wire logic                    awvalid,
  output logic                         awready,
  // axi4-lite write data
  input  wire logic [`IVOB_DATA_W-1:0] wdata,
  input  wire logic [3:0]              wstrb,
  input  wire logic                    wvalid,
  output logic                         wready,
  // axi4-lite write response
  output logic [1:0]                   bresp,
  output logic                         bvalid,
  input  wire logic                    bready,
  // axi4-lite read address
  input  wire logic [`IVOB_ADDR_W-1:0] araddr,
  input  wire logic [2:0]              arprot,
  input  wire logic                    arvalid,
  output logic                         arready,
  // axi4-lite read data
  output logic [`IVOB_DATA_W-1:0]      rdata,
  output logic [1:0]                   rresp,
  output logic                         rvalid,
  input  wire logic                    rready,
  // peripheral events, one cycle pulses on aclk
  input  wire logic [N_EVT-1:0]        periph_evt,
  // level interrupt, unmasked flag pending
  output logic                         irq
);
  import ivob_pkg::*;

  localparam int NV = `IVOB_NUM_VEC;
  localparam int AW = `IVOB_ADDR_W;
  localparam int DW = `IVOB_DATA_W;
  // refuse event counts the 32-bit registers cannot hold
  if (N_EVT < 1 || N_EVT > DW) begin : g_chk
    $error("N_EVT must lie between 1 and 32");
  end
  // base addresses of the vector offset registers
  localparam logic [AW-1:0] VEC_ADDR [NV] = '{
    `IVOB_VOFF41_ADDR, `IVOB_VOFF42_ADDR, `IVOB_VOFF43_ADDR,
    `IVOB_VOFF44_ADDR, `IVOB_VOFF45_ADDR, `IVOB_VOFF46_ADDR,
    `IVOB_VOFF47_ADDR, `IVOB_VOFF48_ADDR, `IVOB_VOFF49_ADDR,
    `IVOB_VOFF50_ADDR, `IVOB_VOFF53_ADDR, `IVOB_VOFF54_ADDR,
    `IVOB_VOFF55_ADDR, `IVOB_VOFF56_ADDR};
  wr_state_t                wr_st_ff;            // write channel state
  logic                     awready_ff;          // low while address held
  logic                     wready_ff;           // low while data held
  logic [AW-1:0]            wr_addr_ff;          // held write address
  logic [DW-1:0]            wr_data_ff;          // held write data
  logic [3:0]               wr_strb_ff;          // held byte strobes
  logic                     bvalid_ff;           // write answer pending
  logic [1:0]               bresp_ff;            // write answer code
  logic                     arready_ff;          // low while read answer pending
  logic                     rvalid_ff;           // read answer pending
  logic [DW-1:0]            rdata_ff;            // read answer data
  logic [1:0]               rresp_ff;            // read answer code
  logic [DW-1:0]            rd_mask_ff;          // implemented bits read
  logic [N_EVT-1:0]         flags_ff;            // sticky interrupt flags
  logic [N_EVT-1:0]         ien_ff;              // interrupt enable mask
  logic [N_EVT-1:0]         pen_ff;              // peripheral enables
  logic [`IVOB_VECTOR_OFFSET_FIELD_W-1:0]  vector_offset_field_ff [NV];        // vector offset fields
  logic                     irq_ff;              // registered interrupt
  logic                     wr_fire;             // write performed now
  reg_grp_t                 w_grp;               // write target group
  alias_op_t                w_op;                // write alias operation
  logic [DW-1:0]            w_mask;              // byte lanes written
  logic [NV-1:0]            w_vhit;              // write hits vector i
  reg_grp_t                 r_grp;               // read target group
  alias_op_t                r_op;                // read alias operation
  logic [NV-1:0]            r_vhit;              // read hits vector i
  logic [DW-1:0]            rd_val;              // read mux value
  logic [DW-1:0]            rd_msk;              // read mux live bits
  logic                     rd_ok;               // read address mapped
  logic [N_EVT-1:0]         evt_set;             // events that set flags
  logic [N_EVT-1:0]         nxt_flags;           // next flag value
  logic [N_EVT-1:0]         nxt_ien;             // next enable mask
  logic [N_EVT-1:0]         nxt_pen;             // next peripheral enable

  // group of an address once the alias bits are stripped
  function automatic reg_grp_t grp_of(input logic [AW-1:0] a,
                                      input logic          vhit);
    logic [AW-1:0] base;
    base = a & ~`IVOB_ALIAS_MASK;
    if (vhit)                         grp_of = grp_vec;
    else if (base == `IVOB_FLAG_ADDR) grp_of = grp_flag;
    else if (base == `IVOB_IEN_ADDR)  grp_of = grp_ien;
    else if (base == `IVOB_PEN_ADDR)  grp_of = grp_pen;
    else                              grp_of = grp_none;
  endfunction : grp_of
  // apply a base write or an alias operation to a register
  function automatic logic [DW-1:0] apply_op(input logic [DW-1:0] old,
                                             input logic [DW-1:0] d,
                                             input logic [DW-1:0] m,
                                             input alias_op_t     op);
    case (op)
      op_clr:  apply_op = old & ~(d & m);
      op_set:  apply_op = old | (d & m);
      op_inv:  apply_op = old ^ (d & m);
      default: apply_op = (old & ~m) | (d & m);
    endcase
  endfunction : apply_op
  // per-vector address match for both channels
  for (genvar i = 0; i < NV; i++) begin : g_vhit
    assign w_vhit[i] = (wr_addr_ff[AW-1:2] == VEC_ADDR[i][AW-1:2]);
    assign r_vhit[i] = (araddr[AW-1:2] == VEC_ADDR[i][AW-1:2]);
  end
  // write decode and byte lane mask
  always_comb begin
    w_grp  = grp_of(wr_addr_ff, |w_vhit);
    w_op   = alias_op_t'(wr_addr_ff[`IVOB_OP_HI:`IVOB_OP_LO]);
    w_mask = {{8{wr_strb_ff[3]}}, {8{wr_strb_ff[2]}},
              {8{wr_strb_ff[1]}}, {8{wr_strb_ff[0]}}};
  end
  assign wr_fire = ce && wr_st_ff == wr_collect && !awready_ff
                   && !wready_ff;
  // write channel: hold address and data, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_st_ff   <= wr_collect;
      awready_ff <= 1'b1;
      wready_ff  <= 1'b1;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
      wr_strb_ff <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= `IVOB_RESP_OKAY;
    end else if (ce) begin
      case (wr_st_ff)
        wr_collect: begin
          // address and data are taken in either order
          if (awvalid && awready_ff) begin
            wr_addr_ff <= awaddr;
            awready_ff <= 1'b0;
          end
          if (wvalid && wready_ff) begin
            wr_data_ff <= wdata;
            wr_strb_ff <= wstrb;
            wready_ff  <= 1'b0;
          end
          // both held: the write lands now, answer follows
          if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff  <= (w_grp == grp_none) ? `IVOB_RESP_SLVERR
                                             : `IVOB_RESP_OKAY;
            wr_st_ff  <= wr_resp;
          end
        end
        wr_resp: begin
          // reopen both channels once the answer is taken
          if (bready) begin
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b1;
            wready_ff  <= 1'b1;
            wr_st_ff   <= wr_collect;
          end
        end
        default: wr_st_ff <= wr_collect;
      endcase
    end
  end
  // read mux, alias addresses read as zero
  always_comb begin
    r_grp  = grp_of(araddr, |r_vhit);
    r_op   = alias_op_t'(araddr[`IVOB_OP_HI:`IVOB_OP_LO]);
    rd_val = '0;
    rd_msk = '0;
    rd_ok  = 1'b1;
    case (r_grp)
      grp_flag: if (r_op == op_base) begin
        rd_val = DW'(flags_ff);
        rd_msk = DW'({N_EVT{1'b1}});
      end
      grp_ien: if (r_op == op_base) begin
        rd_val = DW'(ien_ff);
        rd_msk = DW'({N_EVT{1'b1}});
      end
      grp_pen: if (r_op == op_base) begin
        rd_val = DW'(pen_ff);
        rd_msk = DW'({N_EVT{1'b1}});
      end
      grp_vec: begin
        for (int i = 0; i < NV; i++) begin
          if (r_vhit[i]) begin
            rd_val = DW'({vector_offset_field_ff[i], 1'b0});
          end
        end
        rd_msk = DW'({{`IVOB_VECTOR_OFFSET_FIELD_W{1'b1}}, 1'b0});
      end
      default: rd_ok = 1'b0;
    endcase
  end
  // read channel: one answer per accepted address
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b1;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= '0;
      rresp_ff   <= `IVOB_RESP_OKAY;
      rd_mask_ff <= '0;
    end else if (ce) begin
      if (arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff  <= 1'b1;
        rdata_ff   <= rd_val & rd_msk;
        rd_mask_ff <= rd_msk;
        rresp_ff   <= rd_ok ? `IVOB_RESP_OKAY : `IVOB_RESP_SLVERR;
      end else if (rvalid_ff && rready) begin
        rvalid_ff  <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end
  assign evt_set = periph_evt & pen_ff;
  // next values of the aliased control registers
  always_comb begin
    nxt_flags = flags_ff;
    nxt_ien   = ien_ff;
    nxt_pen   = pen_ff;
    if (wr_fire && w_grp == grp_flag) begin
      nxt_flags = N_EVT'(apply_op(DW'(flags_ff), wr_data_ff, w_mask,
                                  w_op));
    end
    if (wr_fire && w_grp == grp_ien) begin
      nxt_ien = N_EVT'(apply_op(DW'(ien_ff), wr_data_ff, w_mask, w_op));
    end
    if (wr_fire && w_grp == grp_pen) begin
      nxt_pen = N_EVT'(apply_op(DW'(pen_ff), wr_data_ff, w_mask, w_op));
    end
    // a same-cycle event beats a clear
    nxt_flags = nxt_flags | evt_set;
  end
  // control registers and the interrupt line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_ff <= N_EVT'(`IVOB_CTRL_RST);
      ien_ff   <= N_EVT'(`IVOB_CTRL_RST);
      pen_ff   <= N_EVT'(`IVOB_CTRL_RST);
      irq_ff   <= 1'b0;
    end else if (ce) begin
      flags_ff <= nxt_flags;
      ien_ff   <= nxt_ien;
      pen_ff   <= nxt_pen;
      irq_ff   <= |(flags_ff & ien_ff);
    end
  end
  // vector offset storage, one register per vector
  for (genvar i = 0; i < NV; i++) begin : g_vector_offset_field
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        vector_offset_field_ff[i] <= `IVOB_VECTOR_OFFSET_FIELD_RST;
      end else if (ce && wr_fire && w_vhit[i]) begin
        vector_offset_field_ff[i] <= vector_offset_field_ff[i] & ~w_mask[`IVOB_VECTOR_OFFSET_FIELD_MSB:`IVOB_VECTOR_OFFSET_FIELD_LSB]
                    | wr_data_ff[`IVOB_VECTOR_OFFSET_FIELD_MSB:`IVOB_VECTOR_OFFSET_FIELD_LSB]
                    & w_mask[`IVOB_VECTOR_OFFSET_FIELD_MSB:`IVOB_VECTOR_OFFSET_FIELD_LSB];
      end
    end
  end
  // ports straight from flip-flops
  assign awready = awready_ff;
  assign wready  = wready_ff;
  assign bvalid  = bvalid_ff;
  assign bresp   = bresp_ff;
  assign arready = arready_ff;
  assign rvalid  = rvalid_ff;
  assign rdata   = rdata_ff;
  assign rresp   = rresp_ff;
  assign irq     = irq_ff;
  // helper terms read only by the checks below
  logic [3:0] vidx_w;                            // index of written vector
  logic       vector_offset_field_any;                          // some offset nonzero
  always_comb begin
    vidx_w   = '0;
    vector_offset_field_any = 1'b0;
    for (int i = 0; i < NV; i++) begin
      if (w_vhit[i]) vidx_w = 4'(i);
      vector_offset_field_any = vector_offset_field_any | (|vector_offset_field_ff[i]);
    end
  end
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // clear alias write drops the written ones, events excepted
  property p_flag_clr;
    wr_fire && w_grp == grp_flag && w_op == op_clr
      |=> flags_ff == (($past(flags_ff) & ~N_EVT'($past(wr_data_ff)
                         & $past(w_mask))) | $past(evt_set));
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("clear alias did not clear the written flags");
  // full-word base write to an offset lands exactly
  property p_vector_offset_field_write;
    wr_fire && w_grp == grp_vec && wr_strb_ff == 4'hf
      |=> vector_offset_field_ff[$past(vidx_w)]
          == $past(wr_data_ff[`IVOB_VECTOR_OFFSET_FIELD_MSB:`IVOB_VECTOR_OFFSET_FIELD_LSB]);
  endproperty
  a_vector_offset_field_write: assert property (p_vector_offset_field_write)
    else $error("offset write did not replace the stored value");
  // enabled event shows in the flags next cycle
  property p_evt_sets;
    ce && |evt_set |=> (flags_ff & $past(evt_set)) == $past(evt_set);
  endproperty
  a_evt_sets: assert property (p_evt_sets)
    else $error("enabled event failed to set its flag");

  // disabled interrupt does not stop the flag
  sequence s_masked_evt;
    ce && |(evt_set & ~ien_ff);
  endsequence
  property p_evt_unmasked;
    s_masked_evt |=> |(flags_ff & $past(evt_set & ~ien_ff));
  endproperty
  a_evt_unmasked: assert property (p_evt_unmasked)
    else $error("flag setting depended on the interrupt enable");

  // flags hold without a flag-register write
  property p_flag_hold;
    !(wr_fire && w_grp == grp_flag)
      |=> (flags_ff & $past(flags_ff)) == $past(flags_ff);
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag fell without software clearing it");

  // read answer carries no dead bits
  sequence s_rd_take;
    ce && arvalid && arready_ff;
  endsequence
  property p_rd_dead_zero;
    s_rd_take |=> rvalid_ff && (rdata_ff & ~rd_mask_ff) == '0;
  endproperty
  a_rd_dead_zero: assert property (p_rd_dead_zero)
    else $error("unimplemented bits read as nonzero");

  // offsets are zero right after reset
  property p_vector_offset_field_reset;
    !$past(aresetn) |-> !vector_offset_field_any && flags_ff == '0;
  endproperty
  a_vector_offset_field_reset: assert property (p_vector_offset_field_reset)
    else $error("offsets not zero after reset");

endmodule : interrupt_vector_offset_bank

// ===== interrupt_vector_offset_bank_test.sv
// self-checking bench for the vector offset bank
`timescale 1ns/1ps
`include "ivob_defs.svh"

module interrupt_vector_offset_bank_test;
  localparam int          N_EVT = 8;             // event sources under test
  localparam logic [31:0] FMASK = 32'h0003fffe;  // offset field bits
  localparam logic [31:0] EMASK = 32'h000000ff;  // implemented event bits
  localparam logic [11:0] FLG   = `IVOB_FLAG_ADDR;
  localparam logic [11:0] IEN   = `IVOB_IEN_ADDR;
  localparam logic [11:0] PEN   = `IVOB_PEN_ADDR;
  logic             aclk, aresetn, ce;           // clock, reset, enable
  logic [11:0]      awaddr, araddr;              // bus addresses
  logic [2:0]       awprot, arprot;              // protection, unused
  logic             awvalid, awready, wvalid, wready;
  logic             bvalid, bready, arvalid, arready;
  logic             rvalid, rready, irq;
  logic [31:0]      wdata, rdata;                // bus data
  logic [3:0]       wstrb;                       // byte lanes
  logic [1:0]       bresp, rresp;                // response codes
  logic [N_EVT-1:0] periph_evt;                  // event pulses
  logic [31:0]      lfsr;                        // random source
  int               failures, checks_done;       // score
  logic [31:0]      vector_offset_field_exp [`IVOB_NUM_VEC];    // expected offsets
  logic [11:0]      vaddr [`IVOB_NUM_VEC] = '{
    `IVOB_VOFF41_ADDR, `IVOB_VOFF42_ADDR, `IVOB_VOFF43_ADDR,
    `IVOB_VOFF44_ADDR, `IVOB_VOFF45_ADDR, `IVOB_VOFF46_ADDR,
    `IVOB_VOFF47_ADDR, `IVOB_VOFF48_ADDR, `IVOB_VOFF49_ADDR,
    `IVOB_VOFF50_ADDR, `IVOB_VOFF53_ADDR, `IVOB_VOFF54_ADDR,
    `IVOB_VOFF55_ADDR, `IVOB_VOFF56_ADDR};

  // design under test
  interrupt_vector_offset_bank #(.N_EVT(N_EVT)) dut_u (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .periph_evt(periph_evt), .irq(irq));

  // free-running clock, 100 ns period
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // one step of the random shift register
  function automatic logic [31:0] lfsr_step(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction : lfsr_step

  // next random word
  task automatic rnd(output logic [31:0] v);
    lfsr = lfsr_step(lfsr);
    v = lfsr;
  endtask : rnd

  // byte strobes to a bit mask
  function automatic logic [31:0] lanes(input logic [3:0] s);
    return {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lanes

  // effect of a base, clear, set or invert write
  function automatic logic [31:0] upd(input logic [31:0] c,
                                      input logic [31:0] d, input int op);
    case (op)
      1: return c & ~d;
      2: return c | d;
      3: return c ^ d;
      default: return d;
    endcase
  endfunction : upd

  // compare one value and keep score
  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // one write, address and data offered together
  task automatic wchk(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
    bit aw_p, w_p;
    aw_p = 1;
    w_p  = 1;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= s;
    wvalid  <= 1'b1;
    // wait for both takes; only the watchdog ends a hang
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && awready) begin
        aw_p = 0;
        awvalid <= 1'b0;
      end
      if (w_p && wready) begin
        w_p = 0;
        wvalid <= 1'b0;
      end
    end
    do begin
      @(posedge aclk);
    end while (!bvalid);
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask : wchk

  // one read, checks data and response
  task automatic rchk(input logic [11:0] a, input logic [31:0] e,
                      input logic [1:0] er);
    araddr  <= a;
    arvalid <= 1'b1;
    // wait for the take, then for the answer
    do begin
      @(posedge aclk);
    end while (!arready);
    arvalid <= 1'b0;
    do begin
      @(posedge aclk);
    end while (!rvalid);
    chk("rresp", {30'h0, er}, {30'h0, rresp});
    if (er === `IVOB_RESP_OKAY) chk("rdata", e, rdata);
  endtask : rchk

  // one cycle of peripheral events
  task automatic pulse(input logic [N_EVT-1:0] v);
    periph_evt <= v;
    @(posedge aclk);
    periph_evt <= '0;
    repeat (2) @(posedge aclk);
  endtask : pulse

  // verdict and end of run
  task automatic summarize();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize

  // hang guard
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    $display("BAD watchdog expected finish seen hang");
    summarize();
  end

  // main sequence
  initial begin
    int i, k, op;
    logic [31:0] d, s, m, cur, pen;
    lfsr = 32'h8f6a;
    failures = 0;
    checks_done = 0;
    aresetn = 1'b0;
    ce = 1'b1;
    awprot = 3'h0;
    arprot = 3'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0;
    wstrb = 4'h0;
    periph_evt = '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    for (i = 0; i < `IVOB_NUM_VEC; i++) begin
      vector_offset_field_exp[i] = 32'h0;
      rchk(vaddr[i], 32'h0, `IVOB_RESP_OKAY); // reset value
    end
    rchk(FLG, 32'h0, `IVOB_RESP_OKAY); // flags clear
    $display("test reset done");
    // plain replace, byte lanes, field mask
    for (k = 0; k < 3; k++) begin
      for (i = 0; i < `IVOB_NUM_VEC; i++) begin
        rnd(d);
        rnd(s);
        m = lanes((k == 0) ? 4'hf : s[3:0]);
        wchk(vaddr[i], d, k == 0 ? 4'hf : s[3:0], `IVOB_RESP_OKAY);
        vector_offset_field_exp[i] = ((vector_offset_field_exp[i] & ~m) | (d & m)) & FMASK;
      end
      for (i = 0; i < `IVOB_NUM_VEC; i++)
        rchk(vaddr[i], vector_offset_field_exp[i], `IVOB_RESP_OKAY); // field only
    end
    wchk(vaddr[0], 32'hffffffff, 4'hf, `IVOB_RESP_OKAY); // all ones
    rchk(vaddr[0], FMASK, `IVOB_RESP_OKAY); // unimplemented zero
    // no register in the gap between the offsets at 12'h608 and 12'h614
    wchk(12'h60c, 32'hffffffff, 4'hf, `IVOB_RESP_SLVERR); // gap
    wchk(12'h610, 32'h0, 4'hf, `IVOB_RESP_SLVERR); // gap
    rchk(12'h60c, 32'h0, `IVOB_RESP_SLVERR); // gap read
    rchk(vaddr[9], vector_offset_field_exp[9], `IVOB_RESP_OKAY); // untouched
    $display("test offsets done");
    // aliases on flag, enable and peripheral enable
    for (i = 0; i < 3; i++) begin
      rnd(d);
      cur = d & EMASK;
      wchk(12'(i * 16), d, 4'hf, `IVOB_RESP_OKAY); // base
      for (op = 1; op < 4; op++) begin
        rnd(d);
        wchk(12'(i * 16 + op * 4), d, 4'hf, `IVOB_RESP_OKAY);
        cur = upd(cur, d, op) & EMASK;
        rchk(12'(i * 16), cur, `IVOB_RESP_OKAY); // alias effect
        rchk(12'(i * 16 + op * 4), 32'h0, `IVOB_RESP_OKAY); // reads 0
      end
      wchk(12'(i * 16), 32'h0, 4'hf, `IVOB_RESP_OKAY); // base
    end
    $display("test aliases done");
    rnd(d);
    pen = (d & EMASK) | 32'h1;
    wchk(PEN, pen, 4'hf, `IVOB_RESP_OKAY); // enables
    pulse('1);
    rchk(FLG, pen, `IVOB_RESP_OKAY); // only enabled sources
    chk("irq", 32'h0, {31'h0, irq}); // disabled interrupt stays low
    repeat (20) @(posedge aclk);
    rchk(FLG, pen, `IVOB_RESP_OKAY); // flags persist
    wchk(IEN + 12'h8, pen, 4'hf, `IVOB_RESP_OKAY); // set alias
    repeat (2) @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq}); // pending flag raises irq
    wchk(FLG + 12'h4, pen & -pen, 4'hf, `IVOB_RESP_OKAY);
    rchk(FLG, pen & ~(pen & -pen), `IVOB_RESP_OKAY); // partial clear
    wchk(FLG + 12'h4, 32'hffffffff, 4'hf, `IVOB_RESP_OKAY);
    rchk(FLG, 32'h0, `IVOB_RESP_OKAY); // software clear
    repeat (2) @(posedge aclk);
    chk("irq", 32'h0, {31'h0, irq}); // irq drops after clear
    wchk(IEN + 12'h4, EMASK, 4'hf, `IVOB_RESP_OKAY); // clear alias
    pulse(N_EVT'(pen));
    rchk(FLG, pen, `IVOB_RESP_OKAY); // masked still sets
    chk("irq", 32'h0, {31'h0, irq}); // masked interrupt low
    // clock enable low freezes the flags, events are lost
    wchk(FLG + 12'h4, 32'hffffffff, 4'hf, `IVOB_RESP_OKAY);
    ce <= 1'b0;
    pulse('1);
    ce <= 1'b1;
    rchk(FLG, 32'h0, `IVOB_RESP_OKAY); // frozen, no set
    $display("test events done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rchk(vaddr[5], 32'h0, `IVOB_RESP_OKAY); // reset clears offset
    rchk(FLG, 32'h0, `IVOB_RESP_OKAY); // reset clears flags
    chk("irq", 32'h0, {31'h0, irq}); // irq low after reset
    $display("test rereset done");
    summarize();
  end
endmodule : interrupt_vector_offset_bank_test
